// ---- src/mct_pkg.sv ----
package mct_pkg;

  // Register word indices; byte address is four times the index
  localparam logic [31:0] IDX_CTRL1   = 32'hffff82c0;
  localparam logic [31:0] IDX_CTRL2   = 32'hffff82c6;
  localparam logic [31:0] IDX_CTRL3   = 32'hffff8206;
  localparam logic [31:0] IDX_CTRL4   = 32'hffff8207;
  localparam logic [31:0] IDX_CTRL5   = 32'hffff820c;
  localparam logic [31:0] IDX_STATUS  = 32'hffff8205;
  localparam logic [31:0] IDX_IRQ_EN  = 32'hffff8204;
  localparam logic [31:0] IDX_CNT4    = 32'hffff8300;
  localparam logic [31:0] IDX_GEN4A   = 32'hffff8301;
  localparam logic [31:0] IDX_CNT5    = 32'hffff8302;
  localparam logic [31:0] IDX_GEN5A   = 32'hffff8303;
  localparam logic [31:0] IDX_GEN5B   = 32'hffff8304;
  localparam logic [31:0] IDX_IOC4A   = 32'hffff8305;
  localparam logic [31:0] IDX_IOC5A   = 32'hffff8306;

  // Status bit positions
  localparam int BIT_C4A   = 3;
  localparam int BIT_WRAP5 = 2;
  localparam int BIT_C5B   = 1;
  localparam int BIT_C5A   = 0;

  // Field layouts and reset values
  localparam logic [7:0]  TCR_WMASK   = 8'h37;
  localparam logic [7:0]  TCR_RST     = 8'h00;
  localparam logic [3:0]  STATUS_RST  = 4'h0;
  localparam logic [3:0]  IRQ_EN_RST  = 4'h0;
  localparam logic [7:0]  IOC_RST     = 8'h00;
  localparam logic [15:0] CNT_RST     = 16'h0000;
  localparam logic [15:0] GR_RST      = 16'hffff;
  localparam logic [15:0] CNT_MAX     = 16'hffff;
  localparam logic [4:0]  PRESC_RST   = 5'h00;
  localparam int          IOC_A_LSB   = 0;
  localparam int          IOC_B_LSB   = 4;
  localparam int          NUM_CH      = 5;
  localparam int          NUM_DIV     = 6;

  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;
  localparam logic [1:0] EDGE_OFF  = 2'h3;
  localparam logic [2:0] SRC_EXTA  = 3'h6;
  localparam logic [2:0] SRC_EXTB  = 3'h7;

  typedef struct packed {
    logic [1:0] rsvdHi;
    logic [1:0] edgeSel;
    logic       rsvdMid;
    logic [2:0] srcSel;
  } mct_tcr_t;

  // Three-bit general register mode: msb set means capture
  typedef struct packed {
    logic       capture;
    logic [1:0] edgeSel;
  } mct_ioc_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ACK  = 2'b01
  } mct_bus_state_t;

endpackage

// ---- src/mct_flag.sv ----
`timescale 1ns/1ps
`default_nettype none
module mct_flag (
  input  wire logic ref_clk,
  input  wire logic rstn,
  input  wire logic setEvt,
  input  wire logic readOne,
  input  wire logic writeZero,
  output logic      flag
);
  import mct_pkg::*;

  logic armReg;

  // arm only after reading a one
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      armReg <= 1'b0;
    else if (!flag)
      armReg <= 1'b0;
    else if (readOne)
      armReg <= 1'b1;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      flag <= 1'b0;
    else if (setEvt)
      flag <= 1'b1;
    else if (writeZero && armReg)
      flag <= 1'b0;
  end

  a_flag_set_wins: assert property (@(posedge ref_clk) disable iff (!rstn)
    setEvt |=> flag) else $error("flag lost a set event");
  a_flag_no_unarmed: assert property (@(posedge ref_clk) disable iff (!rstn)
    (flag && !armReg) |=> flag) else $error("flag cleared without prior read");
endmodule // mct_flag
`default_nettype wire

// ---- src/mct_count_clock.sv ----
`timescale 1ns/1ps
`default_nettype none
module mct_count_clock (
  input  wire logic                          ref_clk,
  input  wire logic                          rstn,
  input  wire mct_pkg::mct_tcr_t             cfg,
  input  wire logic [mct_pkg::NUM_DIV-1:0]   prescTick,
  input  wire logic                          extA,
  input  wire logic                          extB,
  output logic                               tick
);
  import mct_pkg::*;

  logic extSel;
  logic extPrevReg;
  logic extRise;
  logic extFall;
  logic extTick;

  assign extSel  = (cfg.srcSel == SRC_EXTB) ? extB : extA;
  assign extRise = extSel && !extPrevReg;
  assign extFall = !extSel && extPrevReg;

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      extPrevReg <= 1'b0;
    else
      extPrevReg <= extSel;
  end

  always_comb
  begin
    case (cfg.edgeSel)
      EDGE_RISE: extTick = extRise;
      EDGE_FALL: extTick = extFall;
      EDGE_BOTH: extTick = extRise || extFall;
      default:   extTick = 1'b0;
    endcase
  end

  // codes 110 and 111 use the pins
  always_comb
  begin
    if (cfg.srcSel[2:1] == 2'b11)
      tick = extTick;
    else
      tick = prescTick[cfg.srcSel];
  end

  a_ext_off_quiet: assert property (@(posedge ref_clk) disable iff (!rstn)
    (cfg.srcSel[2:1] == 2'b11 && cfg.edgeSel == EDGE_OFF) |-> !tick)
    else $error("external clock counted while disabled");
  a_div_one_tick: assert property (@(posedge ref_clk) disable iff (!rstn)
    (cfg.srcSel == 3'h0) |-> tick) else $error("undivided clock missed a tick");
endmodule // mct_count_clock
`default_nettype wire

// ---- src/mct_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
module mct_timer (
  input  wire logic        ref_clk,
  input  wire logic        rstn,
  input  wire logic [31:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        extClockPinFirst,
  input  wire logic        extClockPinSecond,
  input  wire logic        capture4aPin,
  input  wire logic        capture5aPin,
  input  wire logic        capture5bPin,
  output logic [4:0]       countTick,
  output logic             irq
);
  import mct_pkg::*;

  mct_bus_state_t busState;
  logic           req;
  logic           accept;
  logic           wrDone;
  logic           rdDone;
  logic [31:0]    rdMux;
  logic           hit;

  mct_tcr_t       tcrReg [NUM_CH];
  logic [3:0]     irqEnReg;
  logic [3:0]     status;
  logic [7:0]     ioc4aReg;
  logic [7:0]     ioc5aReg;
  logic [15:0]    cnt4Reg;
  logic [15:0]    cnt5Reg;
  logic [15:0]    gr4aReg;
  logic [15:0]    gr5aReg;
  logic [15:0]    gr5bReg;
  logic [4:0]     prescReg;
  logic [NUM_DIV-1:0] prescTick;

  logic [1:0]     extAMeta;
  logic [1:0]     extBMeta;
  logic [2:0]     capMeta [3];
  logic [2:0]     capSync [3];
  logic [2:0]     capPrevReg;
  logic [2:0]     capHit;
  mct_ioc_t       mode [3];
  logic [2:0]     cmpHit;
  logic [3:0]     setEvt;
  logic [3:0]     readOne;
  logic           wrStatus;

  // Avalon slave: one wait cycle, then answer
  assign req             = avs_read || avs_write;
  assign accept          = (busState == BUS_ACK);
  assign avs_waitrequest = req && !accept;
  assign wrDone          = avs_write && accept && avs_byteenable[0];
  assign rdDone          = avs_read && accept;

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      busState <= BUS_IDLE;
    else
      case (busState)
        BUS_IDLE: busState <= req ? BUS_ACK : BUS_IDLE;
        BUS_ACK:  busState <= BUS_IDLE;
        default:  busState <= BUS_IDLE;
      endcase
  end

  always_comb
  begin
    hit   = 1'b1;
    rdMux = 32'h0000_0000;
    case (avs_address)
      IDX_CTRL1:  rdMux[7:0] = tcrReg[0] & TCR_WMASK;
      IDX_CTRL2:  rdMux[7:0] = tcrReg[1] & TCR_WMASK;
      IDX_CTRL3:  rdMux[7:0] = tcrReg[2] & TCR_WMASK;
      IDX_CTRL4:  rdMux[7:0] = tcrReg[3] & TCR_WMASK;
      IDX_CTRL5:  rdMux[7:0] = tcrReg[4] & TCR_WMASK;
      IDX_STATUS: rdMux[3:0] = status;
      IDX_IRQ_EN: rdMux[3:0] = irqEnReg;
      IDX_IOC4A:  rdMux[7:0] = ioc4aReg;
      IDX_IOC5A:  rdMux[7:0] = ioc5aReg;
      IDX_CNT4:   rdMux[15:0] = cnt4Reg;
      IDX_CNT5:   rdMux[15:0] = cnt5Reg;
      IDX_GEN4A:  rdMux[15:0] = gr4aReg;
      IDX_GEN5A:  rdMux[15:0] = gr5aReg;
      IDX_GEN5B:  rdMux[15:0] = gr5bReg;
      default:    hit = 1'b0;
    endcase
  end

  // Read data latched in the wait cycle
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      avs_readdata <= 32'h0000_0000;
    else if (avs_read && !accept)
      avs_readdata <= hit ? rdMux : 32'h0000_0000;
  end

  // Control and enable registers
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < NUM_CH; i++)
        tcrReg[i] <= TCR_RST;
    end
    else if (wrDone)
    begin
      case (avs_address)
        IDX_CTRL1: tcrReg[0] <= avs_writedata[7:0] & TCR_WMASK;
        IDX_CTRL2: tcrReg[1] <= avs_writedata[7:0] & TCR_WMASK;
        IDX_CTRL3: tcrReg[2] <= avs_writedata[7:0] & TCR_WMASK;
        IDX_CTRL4: tcrReg[3] <= avs_writedata[7:0] & TCR_WMASK;
        IDX_CTRL5: tcrReg[4] <= avs_writedata[7:0] & TCR_WMASK;
        default:  ;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      irqEnReg <= IRQ_EN_RST;
      ioc4aReg <= IOC_RST;
      ioc5aReg <= IOC_RST;
    end
    else if (wrDone)
    begin
      if (avs_address == IDX_IRQ_EN)
        irqEnReg <= avs_writedata[3:0];
      if (avs_address == IDX_IOC4A)
        ioc4aReg <= avs_writedata[7:0];
      if (avs_address == IDX_IOC5A)
        ioc5aReg <= avs_writedata[7:0];
    end
  end

  // Prescaler: tick k fires once every 2**k cycles
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      prescReg <= PRESC_RST;
    else
      prescReg <= prescReg + 5'h01;
  end

  always_comb
  begin
    prescTick[0] = 1'b1;
    for (int k = 1; k < NUM_DIV; k++)
      prescTick[k] = &(prescReg | ~((5'h01 << k) - 5'h01));
  end

  // Pin synchronisers
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      extAMeta <= 2'h0;
      extBMeta <= 2'h0;
    end
    else
    begin
      extAMeta <= {extAMeta[0], extClockPinFirst};
      extBMeta <= {extBMeta[0], extClockPinSecond};
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < 3; i++)
        capMeta[i] <= 3'h0;
      capPrevReg <= 3'h0;
    end
    else
    begin
      capMeta[0] <= {capMeta[0][1:0], capture4aPin};
      capMeta[1] <= {capMeta[1][1:0], capture5aPin};
      capMeta[2] <= {capMeta[2][1:0], capture5bPin};
      capPrevReg <= {capMeta[2][1], capMeta[1][1], capMeta[0][1]};
    end
  end

  for (genvar c = 0; c < NUM_CH; c++)
  begin : g_clk
    mct_count_clock u_clk (
      .ref_clk   (ref_clk),
      .rstn      (rstn),
      .cfg       (tcrReg[c]),
      .prescTick (prescTick),
      .extA      (extAMeta[1]),
      .extB      (extBMeta[1]),
      .tick      (countTick[c])
    );
  end

  assign mode[0] = ioc4aReg[IOC_A_LSB +: 3];
  assign mode[1] = ioc5aReg[IOC_A_LSB +: 3];
  assign mode[2] = ioc5aReg[IOC_B_LSB +: 3];

  // Capture edge detect on the settled synchroniser stage
  always_comb
  begin
    for (int i = 0; i < 3; i++)
    begin
      capSync[i] = capMeta[i];
      case (mode[i].edgeSel)
        2'h1:    capHit[i] = capSync[i][1] && !capPrevReg[i];
        2'h2:    capHit[i] = !capSync[i][1] && capPrevReg[i];
        2'h3:    capHit[i] = capSync[i][1] != capPrevReg[i];
        default: capHit[i] = 1'b0;
      endcase
      capHit[i] = capHit[i] && mode[i].capture;
    end
  end

  // compare match on channel 4 general A and channel 5 general A and B
  assign cmpHit[0] = !mode[0].capture && (cnt4Reg == gr4aReg) && countTick[3];
  assign cmpHit[1] = !mode[1].capture && (cnt5Reg == gr5aReg) && countTick[4];
  assign cmpHit[2] = !mode[2].capture && (cnt5Reg == gr5bReg) && countTick[4];

  // Counters count on their channel tick
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      cnt4Reg <= CNT_RST;
    else if (wrDone && avs_address == IDX_CNT4)
      cnt4Reg <= avs_writedata[15:0];
    else if (countTick[3])
      cnt4Reg <= cnt4Reg + 16'h0001;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
      cnt5Reg <= CNT_RST;
    else if (wrDone && avs_address == IDX_CNT5)
      cnt5Reg <= avs_writedata[15:0];
    else if (countTick[4])
      cnt5Reg <= cnt5Reg + 16'h0001;
  end

  // capture copies counter into general A or B
  // capture into channel 5 general A
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      gr4aReg <= GR_RST;
      gr5aReg <= GR_RST;
      gr5bReg <= GR_RST;
    end
    else
    begin
      if (capHit[0])
        gr4aReg <= cnt4Reg;
      else if (wrDone && avs_address == IDX_GEN4A)
        gr4aReg <= avs_writedata[15:0];
      if (capHit[1])
        gr5aReg <= cnt5Reg;
      else if (wrDone && avs_address == IDX_GEN5A)
        gr5aReg <= avs_writedata[15:0];
      if (capHit[2])
        gr5bReg <= cnt5Reg;
      else if (wrDone && avs_address == IDX_GEN5B)
        gr5bReg <= avs_writedata[15:0];
    end
  end

  // Flag set sources
  // wrap from maximum to zero
  assign setEvt[BIT_C4A]   = capHit[0] || cmpHit[0];
  assign setEvt[BIT_WRAP5] = countTick[4] && (cnt5Reg == CNT_MAX);
  assign setEvt[BIT_C5B]   = capHit[2] || cmpHit[2];
  assign setEvt[BIT_C5A]   = capHit[1] || cmpHit[1];

  assign wrStatus = wrDone && (avs_address == IDX_STATUS);

  // same clear rule for bit 1
  // same clear rule for bit 0
  for (genvar b = 0; b < 4; b++)
  begin : g_flag
    assign readOne[b] = rdDone && (avs_address == IDX_STATUS) && avs_readdata[b];
    mct_flag u_flag (
      .ref_clk   (ref_clk),
      .rstn      (rstn),
      .setEvt    (setEvt[b]),
      .readOne   (readOne[b]),
      .writeZero (wrStatus && !avs_writedata[b]),
      .flag      (status[b])
    );
  end

  // enable gates each flag onto the interrupt
  assign irq = |(status & irqEnReg);

  sequence s_one_wait;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence

  a_irq_raised: assert property (@(posedge ref_clk) disable iff (!rstn)
    (|(setEvt & irqEnReg) && !(wrDone && avs_address == IDX_IRQ_EN)) |=> irq)
    else $error("enabled flag event raised no interrupt");
  a_wrap_sets_flag: assert property (@(posedge ref_clk) disable iff (!rstn)
    (countTick[4] && cnt5Reg == CNT_MAX) |=> (status[BIT_WRAP5] && cnt5Reg == CNT_RST))
    else $error("wrap did not set flag");
  a_capture_copies: assert property (@(posedge ref_clk) disable iff (!rstn)
    capHit[0] |=> (gr4aReg == $past(cnt4Reg) && status[BIT_C4A]))
    else $error("capture did not copy counter");
  a_compare_b_sets: assert property (@(posedge ref_clk) disable iff (!rstn)
    cmpHit[2] |=> status[BIT_C5B]) else $error("compare B flag not set");
  a_reserved_zero: assert property (@(posedge ref_clk) disable iff (!rstn)
    (rdDone && avs_address == IDX_CTRL5) |-> (avs_readdata[7:6] == 2'h0 && !avs_readdata[3]))
    else $error("reserved control bits not zero");
  a_bus_one_wait: assert property (@(posedge ref_clk) disable iff (!rstn)
    ($rose(req) && busState == BUS_IDLE) |-> s_one_wait)
    else $error("bus answer not after one wait");
endmodule // mct_timer
`default_nettype wire

// ---- tb/mct_timer_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module mct_timer_tb;
  import mct_pkg::*;

  logic        ref_clk       = 1'b0;
  logic        rstn          = 1'b0;
  logic [31:0] avsAddress    = 32'h0;
  logic        avsRead       = 1'b0;
  logic        avsWrite      = 1'b0;
  logic [31:0] avsWritedata  = 32'h0;
  logic [3:0]  avsByteenable = 4'hf;
  logic [31:0] avsReaddata;
  logic        avsWaitrequest;
  logic        extA          = 1'b0;
  logic        extB          = 1'b0;
  logic [2:0]  capPins       = 3'h0;
  logic [4:0]  countTick;
  logic        irq;
  int          errors        = 0;
  int          numChecks     = 0;
  int          seed          = 53848;
  logic [31:0] expQ[$];
  logic [31:0] tcrIdx [5]    = '{IDX_CTRL1, IDX_CTRL2, IDX_CTRL3, IDX_CTRL4, IDX_CTRL5};
  logic [31:0] cntOf [3]     = '{IDX_CNT4, IDX_CNT5, IDX_CNT5};
  logic [31:0] grOf [3]      = '{IDX_GEN4A, IDX_GEN5A, IDX_GEN5B};
  logic [31:0] maskOf [3]    = '{32'h8, 32'h1, 32'h2};
  logic [31:0] extCfg [9]    = '{32'h06, 32'h16, 32'h26, 32'h36, 32'h07, 32'h17, 32'h27,
                                 32'h06, 32'h07};
  logic [1:0]  extPin [9]    = '{2'h1, 2'h1, 2'h1, 2'h1, 2'h2, 2'h2, 2'h2, 2'h2, 2'h1};
  int          extExp [9]    = '{4, 4, 8, 0, 4, 4, 8, 0, 0};

  always #20 ref_clk = ~ref_clk;

  mct_timer mct_timer_inst (
    .ref_clk           (ref_clk),
    .rstn              (rstn),
    .avs_address       (avsAddress),
    .avs_read          (avsRead),
    .avs_write         (avsWrite),
    .avs_writedata     (avsWritedata),
    .avs_byteenable    (avsByteenable),
    .avs_readdata      (avsReaddata),
    .avs_waitrequest   (avsWaitrequest),
    .extClockPinFirst  (extA),
    .extClockPinSecond (extB),
    .capture4aPin      (capPins[0]),
    .capture5aPin      (capPins[1]),
    .capture5bPin      (capPins[2]),
    .countTick         (countTick),
    .irq               (irq)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", numChecks, errors);
    if (errors == 0 && numChecks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // One Avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic [31:0] addr, input logic wrEn, input logic [31:0] data);
    int n;
    @(posedge ref_clk);
    avsAddress   <= addr;
    avsWrite     <= wrEn;
    avsRead      <= ~wrEn;
    avsWritedata <= data;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (avsWaitrequest !== 1'b0 && n < 16);
    avsRead  <= 1'b0;
    avsWrite <= 1'b0;
    if (n >= 16)
    begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, avsWaitrequest, 1'b0);
      end_sim();
    end
  endtask

  task automatic wr(input logic [31:0] addr, input logic [31:0] data);
    bus(addr, 1'b1, data);
  endtask

  task automatic rd(input logic [31:0] addr, input logic [31:0] exp);
    expQ.push_back(exp);
    bus(addr, 1'b0, 32'h0);
  endtask

  // Read results are compared as they are accepted
  always @(posedge ref_clk)
  begin
    if (avsRead === 1'b1 && avsWaitrequest === 1'b0)
    begin
      if (expQ.size() > 0)
        chk(avsReaddata, expQ.pop_front());
      else
      begin
        errors++;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, avsReaddata, 32'h0);
      end
    end
  end

  task automatic irqIs(input logic exp);
    @(posedge ref_clk);
    chk({31'h0, irq}, {31'h0, exp});
  endtask

  task automatic note(input string s);
    $display("test %s done", s);
  endtask

  // Counts ticks of one channel while toggling the chosen pins
  task automatic ticks(input int ch, input int cycles, input logic [1:0] pinSel, output int n);
    n = 0;
    for (int i = 0; i < cycles; i++)
    begin
      @(posedge ref_clk);
      if (countTick[ch] === 1'b1)
        n++;
      extA <= pinSel[0] && i < 32 && i[2];
      extB <= pinSel[1] && i < 32 && i[2];
    end
  endtask

  task automatic run(input logic [31:0] cntIdx, input logic [31:0] tcr, input logic [15:0] start);
    wr(cntIdx, {16'h0, start});
    wr(tcr, 32'h0);
    repeat (8) @(posedge ref_clk);
    wr(tcr, 32'h36);
  endtask

  task automatic clear(input logic [31:0] mask);
    rd(IDX_STATUS, mask);
    wr(IDX_STATUS, 32'hff);
    rd(IDX_STATUS, mask);
    wr(IDX_STATUS, 32'h0);
    rd(IDX_STATUS, 32'h0);
  endtask

  task automatic pulse(input int which);
    @(posedge ref_clk);
    capPins <= 3'h1 << which;
    repeat (4) @(posedge ref_clk);
    capPins <= 3'h0;
    repeat (8) @(posedge ref_clk);
  endtask

  initial
  begin
    logic [31:0] d;
    int          n;
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    for (int i = 0; i < 5; i++)
      rd(tcrIdx[i], 32'h0);
    rd(IDX_STATUS, 32'h0);
    irqIs(1'b0);
    rd(32'hffff8210, 32'h0);
    note("reset");
    for (int i = 0; i < 5; i++)
    begin
      d = $random(seed);
      wr(tcrIdx[i], d);
      rd(tcrIdx[i], d & 32'h37);
    end
    wr(IDX_CTRL1, 32'hff);
    rd(IDX_CTRL1, 32'h37);
    avsByteenable <= 4'h0;
    wr(IDX_CTRL1, 32'h00);
    avsByteenable <= 4'hf;
    rd(IDX_CTRL1, 32'h37);
    wr(32'hffff8210, 32'hff);
    rd(32'hffff8210, 32'h0);
    wr(IDX_CTRL4, 32'h36);
    wr(IDX_CTRL5, 32'h36);
    note("control access");
    for (int k = 0; k < 6; k++)
    begin
      wr(IDX_CTRL1, k);
      ticks(0, 64, 2'h0, n);
      chk(n, 64 >> k);
    end
    wr(IDX_CTRL3, 32'h3);
    ticks(2, 64, 2'h0, n);
    chk(n, 8);
    note("prescaler");
    for (int r = 0; r < 9; r++)
    begin
      wr(IDX_CTRL2, extCfg[r]);
      ticks(1, 48, extPin[r], n);
      chk(n, extExp[r]);
    end
    note("external clock");
    wr(IDX_GEN5A, 32'h10);
    wr(IDX_GEN5B, 32'h20);
    wr(IDX_IRQ_EN, 32'h4);
    run(IDX_CNT5, IDX_CTRL5, 16'hfffd);
    irqIs(1'b1);
    clear(32'h4);
    irqIs(1'b0);
    run(IDX_CNT5, IDX_CTRL5, 16'h000c);
    irqIs(1'b0);
    wr(IDX_IRQ_EN, 32'h1);
    irqIs(1'b1);
    wr(IDX_STATUS, 32'h0);
    clear(32'h1);
    run(IDX_CNT5, IDX_CTRL5, 16'h001c);
    clear(32'h2);
    wr(IDX_GEN4A, 32'h30);
    run(IDX_CNT4, IDX_CTRL4, 16'h002c);
    clear(32'h8);
    note("wrap and compare");
    wr(IDX_IOC4A, 32'h05);
    wr(IDX_IOC5A, 32'h76);
    for (int w = 0; w < 3; w++)
    begin
      d = {16'h0, 16'($random(seed))};
      wr(cntOf[w], d);
      pulse(w);
      rd(grOf[w], d);
      clear(maskOf[w]);
    end
    note("capture");
    end_sim();
  end
endmodule // mct_timer_tb
`default_nettype wire
